// file: src/eta_pkg.sv
// eta_pkg: constants, states and carrier structs for the two-wire user memory port.
// assumes a single 125 MHz system clock; serial pins arrive asynchronously.
package eta_pkg;

  // ==========================================================
  // protocol constants
  localparam logic [3:0] DEV_TYPE = 4'h9;
  localparam logic [7:0] CMD_ACCESS_MEM = 8'h17;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int BUF_DEPTH = 8;
  localparam int MEM_DEPTH = 256;

  // ==========================================================
  // programming time
  localparam int PROG_TIME_MS = 10;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROG_CNT_W = 21;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_IGNORE
  } eta_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic [2:0] a;
  } eta_pins_s;

  typedef struct packed {
    logic commit;
    logic [4:0] page;
    logic [BUF_DEPTH-1:0][7:0] data;
    logic [BUF_DEPTH-1:0] mask;
  } eta_wr_s;

  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic busy;
    logic [PROG_CNT_W-1:0] timer;
  } eta_nvm_s;

  typedef struct packed {
    eta_pins_s s1;
    eta_pins_s s2;
    eta_pins_s s3;
    eta_state_e st;
    eta_state_e nxt;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic ack_ph;
    logic acked;
    logic rd_ok;
    logic [7:0] ptr;
    logic [BUF_DEPTH-1:0][7:0] wbuf;
    logic [BUF_DEPTH-1:0] bvalid;
    logic wr_pend;
    logic commit;
    logic sda_oe;
    logic sda_lvl;
    logic busy;
  } eta_top_s;

endpackage

// file: src/eta_nvm.sv
// eta_nvm: 256-byte user array in flip-flops with a programming timer.
// assumes commit pulses only arrive while not busy; reads are combinational.
`timescale 1ns/1ps
module eta_nvm #(
  parameter int PROG_CYCLES = eta_pkg::PROG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input eta_pkg::eta_wr_s wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic busy
);

  eta_pkg::eta_nvm_s q;
  eta_pkg::eta_nvm_s d;

  // ==========================================================
  // storage and timer
  always_comb begin
    d = q;
    if (wr.commit && !q.busy) begin
      for (int i = 0; i < eta_pkg::BUF_DEPTH; i++) begin
        if (wr.mask[i]) begin
          d.mem[{wr.page, 3'(i)}] = wr.data[i];
        end
      end
      d.busy = 1'b1;
      d.timer = '0;
    end else if (q.busy) begin
      // array already holds the data; busy only models the write cycle time
      if (q.timer == eta_pkg::PROG_CNT_W'(PROG_CYCLES - 1)) begin
        d.busy = 1'b0;
      end else begin
        d.timer = q.timer + eta_pkg::PROG_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.mem[rd_addr];
  assign busy = q.busy;

  // ==========================================================
  // checks
  chk_commit_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr.commit && !q.busy) |=> busy ##1 busy)
    else $error("programming did not hold busy after commit");

endmodule

// file: src/eta_top.sv
// eta_top: device-side two-wire protocol for the 256-byte user memory.
// assumes scl, sda and address straps are asynchronous pins; sda is open drain.
`timescale 1ns/1ps

// Function
// - ack select and memory command byte
// - ack address byte, load pointer
// - ack every written data byte
// - eight-byte wrapping write buffer
// - stop starts programming of buffer
// - start instead of stop discards write
// - nack command byte while programming
// - repeated start with read select, ack, send
// - pointer increments after each read byte
module eta_top #(
  parameter int PROG_CYCLES = eta_pkg::PROG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [2:0] addr_pins,
  output logic sda_o,
  output logic sda_oe,
  output logic prog_busy
);

  eta_pkg::eta_top_s q;
  eta_pkg::eta_top_s d;
  eta_pkg::eta_wr_s wr;
  logic [7:0] rd_data;
  logic nv_busy;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;

  function automatic logic sel_match(input logic [7:0] b, input logic [2:0] a);
    sel_match = (b[7:1] == {eta_pkg::DEV_TYPE, a});
  endfunction

  // ==========================================================
  // pin edges, taken only from the second and third stages
  assign rise = q.s2.scl & ~q.s3.scl;
  assign fall = ~q.s2.scl & q.s3.scl;
  assign start_ev = q.s2.scl & q.s3.scl & q.s3.sda & ~q.s2.sda;
  assign stop_ev = q.s2.scl & q.s3.scl & ~q.s3.sda & q.s2.sda;

  // ==========================================================
  // protocol engine
  always_comb begin
    d = q;
    d.s1 = '{scl: scl_i, sda: sda_i, a: addr_pins};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.commit = 1'b0;
    d.busy = nv_busy;
    if (start_ev) begin
      if (q.wr_pend) begin
        d.wr_pend = 1'b0;
        d.rd_ok = 1'b0;
      end
      d.st = eta_pkg::ST_DEV;
      d.cnt = '0;
      d.ack_ph = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop_ev) begin
      d.commit = q.wr_pend;
      d.wr_pend = 1'b0;
      d.rd_ok = 1'b0;
      d.st = eta_pkg::ST_IDLE;
      d.cnt = '0;
      d.ack_ph = 1'b0;
      d.sda_oe = 1'b0;
    end else if (q.st != eta_pkg::ST_IDLE && q.st != eta_pkg::ST_IGNORE) begin
      if (rise) begin
        if (q.st == eta_pkg::ST_RDATA) begin
          if (q.ack_ph) begin
            d.acked = ~q.s2.sda;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.cnt = q.cnt + 4'h1;
          end
        end else if (!q.ack_ph) begin
          d.sh = {q.sh[6:0], q.s2.sda};
          d.cnt = q.cnt + 4'h1;
        end
      end else if (fall) begin
        if (q.st == eta_pkg::ST_RDATA) begin
          if (q.ack_ph) begin
            d.ack_ph = 1'b0;
            d.cnt = '0;
            if (q.acked) begin
              d.sh = rd_data;
              d.ptr = q.ptr + 8'h01;
              d.sda_oe = ~rd_data[7];
            end else begin
              d.st = eta_pkg::ST_IGNORE;
            end
          end else if (q.cnt == eta_pkg::BITS_PER_BYTE) begin
            d.sda_oe = 1'b0;
            d.ack_ph = 1'b1;
            d.acked = 1'b0;
          end else begin
            d.sda_oe = ~q.sh[7];
          end
        end else if (q.ack_ph) begin
          // end of the ninth clock: release, or drive the first read bit after a read select, and move on
          d.sda_oe = 1'b0;
          d.ack_ph = 1'b0;
          d.cnt = '0;
          if (!q.acked) begin
            d.st = eta_pkg::ST_IGNORE;
          end else begin
            d.st = q.nxt;
            if (q.nxt == eta_pkg::ST_RDATA) begin
              d.sh = rd_data;
              d.ptr = q.ptr + 8'h01;
              d.sda_oe = ~rd_data[7];
            end
          end
        end else if (q.cnt == eta_pkg::BITS_PER_BYTE) begin
          d.ack_ph = 1'b1;
          d.acked = 1'b0;
          d.nxt = eta_pkg::ST_IGNORE;
          case (q.st)
            eta_pkg::ST_DEV: begin
              if (sel_match(q.sh, q.s2.a) && !q.sh[0]) begin
                d.acked = 1'b1;
                d.nxt = eta_pkg::ST_CMD;
              end else if (sel_match(q.sh, q.s2.a) && q.rd_ok) begin
                d.acked = 1'b1;
                d.nxt = eta_pkg::ST_RDATA;
              end
            end
            eta_pkg::ST_CMD: begin
              // other commands belong to the thermometer side and are not answered
              d.acked = (q.sh == eta_pkg::CMD_ACCESS_MEM) && !q.busy;
              d.nxt = eta_pkg::ST_ADDR;
            end
            eta_pkg::ST_ADDR: begin
              d.acked = 1'b1;
              d.ptr = q.sh;
              d.bvalid = '0;
              d.rd_ok = 1'b1;
              d.nxt = eta_pkg::ST_WDATA;
            end
            eta_pkg::ST_WDATA: begin
              d.acked = 1'b1;
              d.wbuf[q.ptr[2:0]] = q.sh;
              d.bvalid[q.ptr[2:0]] = 1'b1;
              d.ptr = {q.ptr[7:3], q.ptr[2:0] + 3'h1};
              d.wr_pend = 1'b1;
              d.rd_ok = 1'b0;
              d.nxt = eta_pkg::ST_WDATA;
            end
            default: begin
              d.acked = 1'b0;
            end
          endcase
          d.sda_oe = d.acked;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // array
  assign wr = '{commit: q.commit, page: q.ptr[7:3], data: q.wbuf, mask: q.bvalid};

  eta_nvm #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_nvm (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr(wr),
    .rd_addr(q.ptr),
    .rd_data(rd_data),
    .busy(nv_busy)
  );

  assign sda_o = q.sda_lvl;
  assign sda_oe = q.sda_oe;
  assign prog_busy = q.busy;

  // ==========================================================
  // checks
  logic decide;
  logic [2:0] ptr_lo;
  logic sh_msb;
  assign decide = fall && !q.ack_ph && q.cnt == eta_pkg::BITS_PER_BYTE && !start_ev && !stop_ev;
  assign ptr_lo = q.ptr[2:0];
  assign sh_msb = q.sh[7];

  sequence s_ack_slot;
    q.sda_oe && q.ack_ph;
  endsequence

  chk_cmd_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && q.st == eta_pkg::ST_CMD && q.sh == eta_pkg::CMD_ACCESS_MEM && !q.busy)
      |=> s_ack_slot)
    else $error("memory command not acknowledged");
  chk_busy_nack: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && q.st == eta_pkg::ST_CMD && q.busy) |=> (!q.sda_oe && q.ack_ph))
    else $error("command acknowledged while programming");
  chk_addr_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && q.st == eta_pkg::ST_ADDR) |=> (q.ptr == $past(q.sh)) and s_ack_slot)
    else $error("start address not loaded");
  chk_data_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && q.st == eta_pkg::ST_WDATA) |=> s_ack_slot ##0 q.wr_pend)
    else $error("write byte not acknowledged");
  chk_buf_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && q.st == eta_pkg::ST_WDATA)
      |=> (q.ptr[2:0] == $past(ptr_lo) + 3'h1) && (q.ptr[7:3] == $past(q.ptr[7:3])))
    else $error("write buffer index did not wrap in page");
  chk_stop_commit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stop_ev && q.wr_pend) |=> q.commit ##2 prog_busy)
    else $error("stop did not start programming");
  chk_start_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (start_ev && q.wr_pend) |=> (!q.wr_pend && !q.commit) ##1 !q.commit)
    else $error("aborted write was committed");
  chk_rd_incr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fall && q.st == eta_pkg::ST_RDATA && q.ack_ph && q.acked && !start_ev && !stop_ev)
      |=> q.ptr == $past(q.ptr) + 8'h01)
    else $error("read pointer did not advance");
  chk_msb_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fall && q.st == eta_pkg::ST_RDATA && !q.ack_ph && q.cnt < eta_pkg::BITS_PER_BYTE
      && !start_ev && !stop_ev) |=> q.sda_oe == !$past(sh_msb))
    else $error("read bit order wrong");

endmodule

// file: verification/eta_master.sv
// eta_master: two-wire bus master model, open-drain data line.
// assumes the device pulls sda low through dev_oe; the line has a pull-up.
`timescale 1ns/1ps
module eta_master (
  input wire logic clk_sys,
  input wire logic dev_oe,
  output logic scl,
  output logic sda
);
  logic drv;
  // ==========================================================
  // wired-and line: a released line floats to the pull-up level
  assign sda = drv & ~dev_oe;
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // also a repeated start, so a retry restarts the whole frame
  task automatic start();
    drv <= 1'b1;
    hold(8);
    scl <= 1'b1;
    hold(8);
    drv <= 1'b0;
    hold(8);
    scl <= 1'b0;
    hold(8);
  endtask
  task automatic stop();
    drv <= 1'b0;
    hold(8);
    scl <= 1'b1;
    hold(8);
    drv <= 1'b1;
    hold(8);
  endtask
  // data moves 2 clocks after scl falls so it never looks like start or stop
  task automatic bitx(input logic b, output logic r);
    drv <= b;
    hold(6);
    scl <= 1'b1;
    hold(4);
    r = sda;
    hold(4);
    scl <= 1'b0;
    hold(2);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(~more, r);
  endtask
endmodule

// file: verification/test_eta_top.sv
// test_eta_top: self-checking bench for the two-wire user memory port.
// assumes eta_master drives the bus; programming time is shortened.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_eta_top;
  localparam int PCYC = 400;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] SEL_W = {eta_pkg::DEV_TYPE, STRAP, 1'b0};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr_pins = STRAP;
  logic scl;
  logic sda;
  logic sda_o;
  logic sda_oe;
  logic prog_busy;
  int err_count = 0;
  int n_compared = 0;
  always #4 clk_sys = ~clk_sys;
  // ==========================================================
  // design and bus master
  eta_top #(.PROG_CYCLES(PCYC)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl),
    .sda_i(sda), .addr_pins(addr_pins), .sda_o(sda_o), .sda_oe(sda_oe),
    .prog_busy(prog_busy));
  eta_master m (.clk_sys(clk_sys), .dev_oe(sda_oe & ~sda_o), .scl(scl), .sda(sda));
  // ==========================================================
  // shared transfers
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic head(input logic [7:0] a);
    logic k;
    m.start();
    m.wr_byte(SEL_W, k);
    `CHK("select ack", 1'b1, k)
    m.wr_byte(eta_pkg::CMD_ACCESS_MEM, k);
    `CHK("command ack", 1'b1, k)
    m.wr_byte(a, k);
    `CHK("address ack", 1'b1, k)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$], input bit abort);
    logic k;
    head(a);
    foreach (d[i]) begin
      m.wr_byte(d[i], k);
      `CHK("data ack", 1'b1, k)
    end
    if (abort) begin
      m.start();
    end
    m.stop();
    `CHK("busy after stop", ~abort, prog_busy)
  endtask
  // bounded retry; a device that never answers ends the run
  task automatic poll();
    logic k;
    int n;
    n = 0;
    k = 1'b0;
    while (!k && n < 20) begin
      m.start();
      m.wr_byte(SEL_W, k);
      m.wr_byte(eta_pkg::CMD_ACCESS_MEM, k);
      m.stop();
      n++;
    end
    `CHK("nack while busy", 1'b1, n > 1)
    `CHK("ack after busy", 1'b1, k)
    if (!k) begin
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
    logic k;
    logic [7:0] b;
    head(a);
    m.start();
    m.wr_byte({eta_pkg::DEV_TYPE, STRAP, 1'b1}, k);
    `CHK("read select ack", 1'b1, k)
    foreach (e[i]) begin
      m.rd_byte(i < e.size() - 1, b);
      `CHK("read byte", e[i], b)
    end
    m.stop();
  endtask
  // ==========================================================
  // scenarios
  task automatic s_basic();
    wr(8'h05, {8'hab, 8'h3c, 8'h81}, 1'b0);
    poll();
    rd(8'h04, {8'h00, 8'hab, 8'h3c, 8'h81, 8'h00});
  endtask
  task automatic s_wrap();
    wr(8'h00, {8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99}, 1'b0);
    poll();
    rd(8'h00, {8'h88, 8'h99, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77});
  endtask
  task automatic s_abort();
    wr(8'h10, {8'h5a, 8'ha5}, 1'b1);
    rd(8'h10, {8'h00, 8'h00});
  endtask
  task automatic s_ptr_wrap();
    wr(8'hfe, {8'hc1, 8'hc2}, 1'b0);
    poll();
    rd(8'hfe, {8'hc1, 8'hc2, 8'h88, 8'h99});
  endtask
  task automatic s_refuse();
    logic k;
    addr_pins <= 3'h2;
    m.start();
    m.wr_byte(SEL_W, k);
    `CHK("foreign select", 1'b0, k)
    m.stop();
    addr_pins <= STRAP;
    m.start();
    m.wr_byte(SEL_W, k);
    m.wr_byte(8'hac, k);
    `CHK("other command", 1'b0, k)
    m.stop();
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK("idle release", 1'b0, sda_oe)
    `CHK("open drain level", 1'b0, sda_o)
    `CHK("idle busy", 1'b0, prog_busy)
    s_basic();
    s_wrap();
    s_abort();
    s_ptr_wrap();
    s_refuse();
    report_and_stop();
  end
endmodule
